// ---- hw/osc_cfg_pkg.sv ----
// Constants for the oscillator source and PLL translation block
package osc_cfg_pkg;
	localparam logic [11:0] RUN_CFG_OFF     = 12'h060;
	localparam logic [11:0] PLL_TRANS_OFF   = 12'h064;

	localparam int MAIN_OFF_BIT     = 0;
	localparam int INT_OFF_BIT      = 1;
	localparam int SRC_LSB          = 4;
	localparam int CRYSTAL_FREQ_SELECT_LSB         = 6;
	localparam int BYPASS_BIT       = 11;
	localparam int MULT_LSB         = 5;

	localparam logic [4:0] CRYSTAL_FREQ_SELECT_RESET   = 5'h0B;
	localparam logic [4:0] CRYSTAL_FREQ_SELECT_MAX     = 5'h16;
	localparam logic [4:0] CRYSTAL_FREQ_SELECT_PLL_MIN = 5'h04;
	localparam logic [1:0] SRC_RESET    = 2'h1;
	localparam logic       MAIN_OFF_RST = 1'b1;
	localparam logic       INT_OFF_RST  = 1'b0;
	localparam logic       BYPASS_RST   = 1'b1;
	localparam logic [8:0] MULT_RST     = 9'h062;
	localparam logic [4:0] RDIV_RST     = 5'h01;

	localparam logic [1:0] SRC_MAIN     = 2'h0;
	localparam logic [1:0] SRC_INT      = 2'h1;
	localparam logic [1:0] SRC_INT_DIV4 = 2'h2;
	localparam logic [1:0] SRC_SLOW     = 2'h3;
endpackage

// ---- hw/osc_source_and_pll_translation.sv ----
// Oscillator source control and PLL translation registers over APB
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module osc_source_and_pll_translation
	import osc_cfg_pkg::*;
(
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Oscillator and PLL controls
	output logic             main_osc_off,
	output logic             internal_osc_off,
	output logic       [1:0] osc_source_sel,
	output logic             pll_bypass,
	output logic       [8:0] pll_mult,
	output logic       [4:0] pll_ref_div
);
	// ****************************************
	// Storage
	// ****************************************
	// Configuration fields
	logic [4:0]  crystal_freq_select_q;
	logic [1:0]  src_q;
	logic        main_off_q;
	logic        int_off_q;
	logic        bypass_q;
	// Translation image
	logic [8:0]  mult_q;
	logic [4:0]  rdiv_q;
	// Table lookup
	logic [8:0]  rom_mult;
	logic [4:0]  rom_rdiv;
	// Next values
	logic [4:0]  crystal_freq_select_d;
	logic [1:0]  src_d;
	logic        main_off_d;
	logic        int_off_d;
	logic        bypass_d;
	logic [8:0]  mult_d;
	logic [4:0]  rdiv_d;
	logic        ready_d;
	logic        err_d;
	logic [31:0] rdata_d;
	logic [31:0] rd_d;
	// Read images
	logic [31:0] cfg_img;
	logic [31:0] xlat_img;

	// ****************************************
	// Decode
	// ****************************************
	wire setup    = psel && !penable;
	wire is_read  = setup && !pwrite;
	wire hit_cfg  = paddr == RUN_CFG_OFF;
	wire hit_xlat = paddr == PLL_TRANS_OFF;
	wire hit_any  = hit_cfg || hit_xlat;
	// Writes commit at the setup edge; the answer never waits
	wire wr_cfg   = setup && pwrite && hit_cfg;
	wire [4:0] crystal_freq_select_w = pwdata[CRYSTAL_FREQ_SELECT_LSB +: 5];

	// ****************************************
	// Read images
	// ****************************************
	// Reserved bits stay zero in both images
	assign cfg_img = {20'h00000, bypass_q, crystal_freq_select_q, src_q, 2'h0,
		int_off_q, main_off_q};
	assign xlat_img = {18'h00000, mult_q, rdiv_q};
	// A miss reads zero, so no stale image leaks onto the bus
	assign rd_d = hit_cfg ? cfg_img : (hit_xlat ? xlat_img : 32'h00000000);

	// ****************************************
	// Next values
	// ****************************************
	// Fields hold unless the configuration word is written
	assign crystal_freq_select_d     = wr_cfg ? crystal_freq_select_w : crystal_freq_select_q;
	assign src_d      = wr_cfg ? pwdata[SRC_LSB +: 2] : src_q;
	assign main_off_d = wr_cfg ? pwdata[MAIN_OFF_BIT] : main_off_q;
	assign int_off_d  = wr_cfg ? pwdata[INT_OFF_BIT] : int_off_q;
	assign bypass_d   = wr_cfg ? pwdata[BYPASS_BIT] : bypass_q;
	// Image trails the code by one cycle; no write path reaches it
	assign mult_d     = rom_mult;
	assign rdiv_d     = rom_rdiv;
	// Unmapped addresses answer with an error, translation writes silently
	assign ready_d    = setup;
	assign err_d      = setup && !hit_any;
	assign rdata_d    = is_read ? rd_d : 32'h00000000;

	// ****************************************
	// Table
	// ****************************************
	pll_xlat_rom u_rom (
		.crystal_freq_select (crystal_freq_select_q),
		.mult                (rom_mult),
		.ref_div             (rom_rdiv)
	);

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crystal_freq_select_q <= CRYSTAL_FREQ_SELECT_RESET;
		end
		else
		begin
			crystal_freq_select_q <= crystal_freq_select_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_q <= SRC_RESET;
		end
		else
		begin
			src_q <= src_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			main_off_q <= MAIN_OFF_RST;
		end
		else
		begin
			main_off_q <= main_off_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_off_q <= INT_OFF_RST;
		end
		else
		begin
			int_off_q <= int_off_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bypass_q <= BYPASS_RST;
		end
		else
		begin
			bypass_q <= bypass_d;
		end
	end

	// ****************************************
	// Translation registers
	// ****************************************
	// Reset loads the reset code's entry, so the image is valid at once
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mult_q <= MULT_RST;
		end
		else
		begin
			mult_q <= mult_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdiv_q <= RDIV_RST;
		end
		else
		begin
			rdiv_q <= rdiv_d;
		end
	end

	// ****************************************
	// Bus answer
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
		end
		else
		begin
			pready <= ready_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pslverr <= 1'b0;
		end
		else
		begin
			pslverr <= err_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
		end
		else
		begin
			prdata <= rdata_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// One register stage keeps every pin glitch-free
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			main_osc_off <= MAIN_OFF_RST;
		end
		else
		begin
			main_osc_off <= main_off_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			internal_osc_off <= INT_OFF_RST;
		end
		else
		begin
			internal_osc_off <= int_off_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_source_sel <= SRC_RESET;
		end
		else
		begin
			osc_source_sel <= src_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pll_bypass <= BYPASS_RST;
		end
		else
		begin
			pll_bypass <= bypass_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pll_mult <= MULT_RST;
		end
		else
		begin
			pll_mult <= mult_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pll_ref_div <= RDIV_RST;
		end
		else
		begin
			pll_ref_div <= rdiv_q;
		end
	end
endmodule
`default_nettype wire

// ---- hw/pll_xlat_rom.sv ----
// Crystal code to PLL multiplier and reference divider table
`timescale 1ns/1ns
`default_nettype none
module pll_xlat_rom
	import osc_cfg_pkg::*;
(
	// Lookup
	input  wire logic [4:0] crystal_freq_select,
	output logic      [8:0] mult,
	output logic      [4:0] ref_div
);
	// Entries are a local choice; the reset code entry matches the reset image
	always_comb
	begin
		unique case (crystal_freq_select)
			5'h04:   begin mult = 9'h1BC; ref_div = 5'h02; end
			5'h05:   begin mult = 9'h142; ref_div = 5'h01; end
			5'h06:   begin mult = 9'h0C6; ref_div = 5'h00; end
			5'h07:   begin mult = 9'h060; ref_div = 5'h00; end
			5'h08:   begin mult = 9'h0A1; ref_div = 5'h00; end
			5'h09:   begin mult = 9'h04E; ref_div = 5'h00; end
			5'h0A:   begin mult = 9'h04C; ref_div = 5'h00; end
			5'h0B:   begin mult = 9'h062; ref_div = 5'h01; end
			5'h0C:   begin mult = 9'h080; ref_div = 5'h01; end
			5'h0D:   begin mult = 9'h034; ref_div = 5'h00; end
			5'h0E:   begin mult = 9'h030; ref_div = 5'h00; end
			5'h0F:   begin mult = 9'h02F; ref_div = 5'h00; end
			5'h10:   begin mult = 9'h026; ref_div = 5'h00; end
			5'h11:   begin mult = 9'h062; ref_div = 5'h01; end
			5'h12:   begin mult = 9'h03F; ref_div = 5'h00; end
			5'h13:   begin mult = 9'h01C; ref_div = 5'h00; end
			5'h14:   begin mult = 9'h01A; ref_div = 5'h00; end
			5'h15:   begin mult = 9'h030; ref_div = 5'h02; end
			5'h16:   begin mult = 9'h016; ref_div = 5'h00; end
			// Codes below 0x04 are PLL-reserved; above 0x16 undefined
			default: begin mult = 9'h000; ref_div = 5'h00; end
		endcase
	end
endmodule
`default_nettype wire

// ---- test/osc_cfg_chk.sv ----
// Bus and control checks for the oscillator block
`timescale 1ns/1ns
`default_nettype none
module osc_cfg_chk
	import osc_cfg_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Bus request
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Bus answer
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Controls
	input wire logic        main_osc_off,
	input wire logic        internal_osc_off,
	input wire logic        pll_bypass,
	input wire logic [1:0]  osc_source_sel,
	input wire logic [8:0]  pll_mult,
	input wire logic [4:0]  pll_ref_div
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire       setup = psel && !penable;
	wire       cfg_w = setup && pwrite && paddr == RUN_CFG_OFF;
	wire       rd    = pready && !pwrite;
	wire       known = paddr == RUN_CFG_OFF || paddr == PLL_TRANS_OFF;
	wire [4:0] ctl   = {pll_bypass, osc_source_sel, internal_osc_off, main_osc_off};
	wire [4:0] wctl  = {pwdata[11], pwdata[5:4], pwdata[1:0]};
	answer_next_a: assert property (setup |=> pready) else $error("no answer");
	ready_cause_a: assert property (pready |-> $past(setup)) else $error("stray ready");
	idle_quiet_a: assert property (!pready |-> prdata == '0 && !pslverr) else $error("noisy");
	bad_addr_a: assert property (pready |-> pslverr == !known) else $error("error flag");
	cfg_zero_a: assert property (rd && paddr == RUN_CFG_OFF |-> (prdata & 32'hFFFF_F00C) == '0)
		else $error("cfg reserved");
	xlat_view_a: assert property (rd && paddr == PLL_TRANS_OFF |-> prdata[31:14] == '0
		##1 {pll_mult, pll_ref_div} == $past(prdata[13:0])) else $error("xlat view");
	ctl_follow_a: assert property (cfg_w |-> ##2 ctl == $past(wctl, 2)) else $error("ctl");
	low_code_a: assert property (cfg_w && pwdata[10:6] < CRYSTAL_FREQ_SELECT_PLL_MIN |-> ##3
		{pll_mult, pll_ref_div} == '0) else $error("low code");
	rst_code_a: assert property (cfg_w && pwdata[10:6] == CRYSTAL_FREQ_SELECT_RESET |-> ##3
		pll_mult == 9'h062 && pll_ref_div == 5'h01) else $error("reset code");
	cover property (cfg_w);
	cover property (rd && paddr == PLL_TRANS_OFF);
	cover property (pready && pslverr);
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the oscillator block
`timescale 1ns/1ns
`default_nettype none
module tb;
	import osc_cfg_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd_data, d;
	logic        pready, pslverr, rd_err, main_osc_off, internal_osc_off, pll_bypass;
	logic [1:0]  osc_source_sel;
	logic [8:0]  pll_mult;
	logic [4:0]  pll_ref_div;
	logic [4:0]  corner [8] = '{5'h00, 5'h03, 5'h04, 5'h16, 5'h1F, 5'h00, 5'h00, 5'h0B};
	int          bad_count = 0, tests_run = 0, seed = 32'hCC338FEA;
	wire [4:0]   ctl_seen = {pll_bypass, osc_source_sel, internal_osc_off, main_osc_off};
	always #5 pclk = ~pclk;
	osc_source_and_pll_translation osc_source_and_pll_translation_i (
		.pclk             (pclk),
		.presetn          (presetn),
		.psel             (psel),
		.penable          (penable),
		.pwrite           (pwrite),
		.paddr            (paddr),
		.pwdata           (pwdata),
		.prdata           (prdata),
		.pready           (pready),
		.pslverr          (pslverr),
		.main_osc_off     (main_osc_off),
		.internal_osc_off (internal_osc_off),
		.osc_source_sel   (osc_source_sel),
		.pll_bypass       (pll_bypass),
		.pll_mult         (pll_mult),
		.pll_ref_div      (pll_ref_div)
	);
	// Codes that have a real table entry
	function automatic logic in_table(input logic [4:0] c);
		return c >= CRYSTAL_FREQ_SELECT_PLL_MIN && c <= CRYSTAL_FREQ_SELECT_MAX;
	endfunction
	// Configuration read image: reserved bits drop out
	function automatic logic [31:0] cfg_exp(input logic [31:0] w);
		return w & 32'h0000_0FF3;
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Psel stays up between calls so back-to-back transfers need no idle cycle
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#5000;
		bad_count++;
		wrap_up();
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, RUN_CFG_OFF, 32'h0);
		chk("cfg rst", rd_data, 32'h0000_0AD1);
		xfer(1'b1, PLL_TRANS_OFF, $random(seed));
		xfer(1'b0, PLL_TRANS_OFF, 32'h0);
		chk("xlat ro", rd_data, 32'h0000_0C41);
		chk("xlat err", rd_err, 1'b0);
		xfer(1'b0, 12'h068, 32'h0);
		chk("hole err", rd_err, 1'b1);
		chk("hole data", rd_data, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			d = $random(seed);
			d[10:6] = (i == 5 || i == 6) ? 5'({$random(seed)} % 23) : corner[i];
			if (d[10:6] < CRYSTAL_FREQ_SELECT_PLL_MIN)
				d[11] = 1'b1;
			xfer(1'b1, RUN_CFG_OFF, d);
			xfer(1'b0, RUN_CFG_OFF, 32'h0);
			chk("cfg", rd_data, cfg_exp(d));
			chk("ctl", ctl_seen, {d[11], d[5:4], d[1:0]});
			xfer(1'b0, PLL_TRANS_OFF, 32'h0);
			if (d[10:6] < CRYSTAL_FREQ_SELECT_PLL_MIN || d[10:6] > CRYSTAL_FREQ_SELECT_MAX)
				chk("xlat off", rd_data, 32'h0);
			if (d[10:6] == CRYSTAL_FREQ_SELECT_RESET)
				chk("xlat back", rd_data, 32'h0000_0C41);
			chk("xlat live", rd_data != 32'h0, in_table(d[10:6]));
			chk("pll pins", {pll_mult, pll_ref_div}, rd_data[13:0]);
		end
		// Mid-run reset must bring back the reset code and its entry
		xfer(1'b1, RUN_CFG_OFF, 32'h0000_0400);
		xfer(1'b0, PLL_TRANS_OFF, 32'h0);
		chk("xlat moved", rd_data != 32'h0000_0C41, 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		presetn <= 1'b0;
		@(posedge pclk);
		chk("rst pll", {pll_mult, pll_ref_div}, {MULT_RST, RDIV_RST});
		chk("rst ctl", ctl_seen, {BYPASS_RST, SRC_RESET, INT_OFF_RST, MAIN_OFF_RST});
		presetn <= 1'b1;
		xfer(1'b0, PLL_TRANS_OFF, 32'h0);
		chk("xlat reload", rd_data, 32'h0000_0C41);
		xfer(1'b0, RUN_CFG_OFF, 32'h0);
		chk("cfg reload", rd_data, 32'h0000_0AD1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		wrap_up();
	end
endmodule
bind osc_source_and_pll_translation osc_cfg_chk osc_cfg_chk_i (
	.pclk             (pclk),
	.presetn          (presetn),
	.psel             (psel),
	.penable          (penable),
	.pwrite           (pwrite),
	.paddr            (paddr),
	.pwdata           (pwdata),
	.prdata           (prdata),
	.pready           (pready),
	.pslverr          (pslverr),
	.main_osc_off     (main_osc_off),
	.internal_osc_off (internal_osc_off),
	.pll_bypass       (pll_bypass),
	.osc_source_sel   (osc_source_sel),
	.pll_mult         (pll_mult),
	.pll_ref_div      (pll_ref_div)
);
`default_nettype wire
